// ---- verilog/dft_defines.vh ----
// Constants for the disk format task file block
// Behaviour
// R1 - Write-long adds four check bytes after sector data.
// R2 - Format requests a sector-size interleave table, byte by byte.
// R3 - Full buffer sets busy; bad drive lines abort with error.
// R4 - Seek unverified; 128 index pulses without seek complete abort.
// R5 - Settled head writes 4E until index.
// R6 - Per sector an ID and nulled data field; count decrements.
// R7 - Host reloads sector count before each format.
// R8 - Backfill 4E after last sector; next index interrupts.
// R9 - Head byte top bit marks a bad block; the code always writes that bit as 0, so o_bad_block stays low.
// R10 - Write gate on 3 bytes after ID check, off 3 after data check; the code keeps the gate on through ST_GAPOF and ST_GAP3.
// R11 - Data field update rewrites 12 zero bytes.
// R12 - ID mark low bits carry cylinder high: FE, FF, FC, FD.
// R13 - Post-data gap 15 bytes, 30 for 512-byte sectors.
// R14 - Chip select high deselects; offsets 1, 7 split read and write.
// R15 - Parameter registers read back last writes.
// R16 - Size/drive/head bit 7: one ECC, zero CRC.
// R17 - Size/drive/head bits 6:5: 256, 512 or 128-byte sectors.
// R18 - Size/drive/head bits 4:3: drive select number.
// R19 - Size/drive/head bits 2:0: head number.
// R20 - Status: busy 7, ready 6, fault 5, seek 4, request 3, corr 2, error 0.
// R21 - Error: bad 7, uncorr 6, ID check 5, no ID 4, abort 2, trk0 1, mark 0.
// R22 - Unrecoverable errors complete normally, flags set.
`ifndef DFT_DEFINES_VH
`define DFT_DEFINES_VH
`define DFT_OFS_DATA     3'h0
`define DFT_OFS_ERRPRE   3'h1
`define DFT_OFS_SECCNT   3'h2
`define DFT_OFS_SECNUM   3'h3
`define DFT_OFS_CYLLO    3'h4
`define DFT_OFS_CYLHI    3'h5
`define DFT_OFS_GEO      3'h6
`define DFT_OFS_STATCMD  3'h7
`define DFT_GEO_EXT      7
`define DFT_ST_BUSY      7
`define DFT_ST_READY     6
`define DFT_ST_WFAULT    5
`define DFT_ST_SEEKDONE  4
`define DFT_ST_XFERREQ   3
`define DFT_ST_CORR      2
`define DFT_ST_ERROR     0
`define DFT_ER_ABORT     2
`define DFT_CMD_FORMAT   4'h5
`define DFT_CMD_WRITE    4'h3
`define DFT_WRLONG_BIT   1
`define DFT_FILL_BYTE    8'h4E
`define DFT_ZERO_BYTE    8'h00
`define DFT_IDMARK_BASE  8'hFE
`define DFT_SEEK_INDEX   8'h80
`define DFT_GATE_DELAY   4'h3
`define DFT_PREAMBLE     5'h0C
`define DFT_GAP_SHORT    5'h0F
`define DFT_GAP_LONG     5'h1E
`define DFT_LONG_EXTRA   10'h004
`define DFT_ID_BYTES     4'h6
`define DFT_DATA_CHECK   3'h2
`define DFT_ECC_CHECK    3'h4
`define DFT_RST_BYTE     8'h00
`endif

// ---- verilog/dft_fifo.v ----
// Small synchronous FIFO carrying host bytes into the sector buffer path
`timescale 1ns/100ps
module dft_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             i_core_clk,
    input  wire             i_rst,
    input  wire             i_ce,
    input  wire             i_wr_valid,
    output wire             o_wr_ready,
    input  wire [WIDTH-1:0] i_wr_data,
    output wire             o_rd_valid,
    input  wire             i_rd_ready,
    output reg  [WIDTH-1:0] o_rd_data
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW:0]      wptr_ff;
    reg [AW:0]      rptr_ff;
    reg [AW:0]      cnt_ff;
    wire            do_wr;
    wire            do_rd;

    assign o_wr_ready = (cnt_ff != DEPTH[AW:0]);
    assign o_rd_valid = (cnt_ff != {(AW+1){1'b0}});
    assign do_wr      = i_wr_valid && o_wr_ready;
    assign do_rd      = o_rd_valid && i_rd_ready;

    always @* begin
        o_rd_data = mem_ff[rptr_ff[AW-1:0]];
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            wptr_ff <= {(AW+1){1'b0}};
            rptr_ff <= {(AW+1){1'b0}};
            cnt_ff  <= {(AW+1){1'b0}};
        end else if (i_ce) begin
            if (do_wr) begin
                mem_ff[wptr_ff[AW-1:0]] <= i_wr_data;
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (do_rd)
                rptr_ff <= rptr_ff + 1'b1;
            cnt_ff <= cnt_ff + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        end
    end
endmodule // dft_fifo

// ---- verilog/dft_task_file.v ----
// Task file, register map and format-track sequencer
`timescale 1ns/100ps
`include "dft_defines.vh"
module dft_task_file #(
    parameter SEEK_INDEX_LIMIT = `DFT_SEEK_INDEX
) (
    input  wire       i_core_clk,
    input  wire       i_rst,
    input  wire       i_ce,
    input  wire       i_cs_n,
    input  wire [2:0] i_reg_sel,
    input  wire       i_read_strobe_n,
    input  wire       i_write_strobe_n,
    input  wire [7:0] i_host_data,
    output reg  [7:0] o_host_data,
    output reg        o_host_data_oe_n,
    output reg        o_transfer_request,
    output reg        o_intrq,
    input  wire       i_index,
    input  wire       i_seek_complete,
    input  wire       i_drive_ready,
    input  wire       i_write_fault,
    input  wire       i_byte_strobe,
    output reg        o_step,
    output reg        o_write_gate,
    output reg  [7:0] o_write_byte,
    output reg        o_write_byte_valid,
    output reg  [3:0] o_drive_sel,
    output reg  [2:0] o_head_sel,
    output reg        o_ecc_mode,
    output reg  [7:0] o_precomp_cyl,
    output reg        o_bad_block
);
    localparam ST_IDLE  = 4'h0;
    localparam ST_FILL  = 4'h1;
    localparam ST_CHECK = 4'h2;
    localparam ST_SEEK  = 4'h3;
    localparam ST_PRE   = 4'h4;
    localparam ST_ID    = 4'h5;
    localparam ST_GAPON = 4'h6;
    localparam ST_ZERO  = 4'h7;
    localparam ST_DATA  = 4'h8;
    localparam ST_CHK   = 4'h9;
    localparam ST_GAPOF = 4'hA;
    localparam ST_GAP3  = 4'hB;
    localparam ST_BACK  = 4'hC;
    localparam ST_WLONG = 4'hD;

    reg  [3:0]  state_ff;
    reg  [9:0]  cnt_ff;
    reg  [7:0]  idx_cnt_ff;
    reg  [7:0]  sec_cnt_ff;
    reg  [7:0]  sec_num_ff;
    reg  [7:0]  cyl_lo_ff;
    reg  [7:0]  cyl_hi_ff;
    reg  [7:0]  geo_ff;
    reg  [7:0]  err_ff;
    reg         busy_ff;
    reg         error_ff;
    reg         corr_ff;
    reg  [7:0]  ilv_ff;
    reg  [2:0]  idx_sync_ff;
    reg  [2:0]  sk_sync_ff;
    reg  [2:0]  rdy_sync_ff;
    reg  [2:0]  wf_sync_ff;
    reg  [2:0]  bs_sync_ff;
    reg         idx_lvl_ff;
    reg         bs_lvl_ff;
    reg         rd_n_d_ff;
    reg         wr_n_d_ff;
    wire        idx_rise;
    wire        bs_rise;
    wire        rd_edge;
    wire        wr_edge;
    wire [7:0]  status;
    reg  [9:0]  sec_bytes;
    wire [4:0]  gap_len;
    wire [2:0]  chk_len;
    wire [7:0]  id_mark;
    wire        fifo_ready;
    wire        fifo_valid;
    wire [7:0]  fifo_data;
    wire        fifo_take;
    reg  [7:0]  id_byte;

    // Last two stages must agree for index and byte strobe
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            idx_sync_ff <= 3'h0;
            sk_sync_ff  <= 3'h0;
            rdy_sync_ff <= 3'h0;
            wf_sync_ff  <= 3'h0;
            bs_sync_ff  <= 3'h0;
            idx_lvl_ff  <= 1'b0;
            bs_lvl_ff   <= 1'b0;
        end else if (i_ce) begin
            idx_sync_ff <= {idx_sync_ff[1:0], i_index};
            sk_sync_ff  <= {sk_sync_ff[1:0], i_seek_complete};
            rdy_sync_ff <= {rdy_sync_ff[1:0], i_drive_ready};
            wf_sync_ff  <= {wf_sync_ff[1:0], i_write_fault};
            bs_sync_ff  <= {bs_sync_ff[1:0], i_byte_strobe};
            if (idx_sync_ff[2] == idx_sync_ff[1])
                idx_lvl_ff <= idx_sync_ff[2];
            if (bs_sync_ff[2] == bs_sync_ff[1])
                bs_lvl_ff <= bs_sync_ff[2];
        end
    end
    assign idx_rise = (idx_sync_ff[2] == idx_sync_ff[1]) && idx_sync_ff[2] && !idx_lvl_ff;
    assign bs_rise  = (bs_sync_ff[2] == bs_sync_ff[1]) && bs_sync_ff[2] && !bs_lvl_ff;

    // Same-clock strobes; act on trailing edge
    assign rd_edge = !i_cs_n && i_read_strobe_n && !rd_n_d_ff;     // [R14]
    assign wr_edge = !i_cs_n && i_write_strobe_n && !wr_n_d_ff;    // [R14]

    always @* begin
        case (geo_ff[6:5])                                     // [R17]
            2'b01:   sec_bytes = 10'h200;
            2'b11:   sec_bytes = 10'h080;
            default: sec_bytes = 10'h100;
        endcase
    end
    assign gap_len = (geo_ff[6:5] == 2'b01) ? `DFT_GAP_LONG : `DFT_GAP_SHORT;  // [R13]
    assign chk_len = geo_ff[`DFT_GEO_EXT] ? `DFT_ECC_CHECK : `DFT_DATA_CHECK;  // [R16]
    assign id_mark = `DFT_IDMARK_BASE ^ {6'h00, cyl_hi_ff[1:0]};  // [R12]

    assign status = {busy_ff, rdy_sync_ff[2], wf_sync_ff[2], sk_sync_ff[2],    // [R20]
                     o_transfer_request, corr_ff, 1'b0, error_ff};

    assign fifo_take = bs_rise && ((state_ff == ST_WLONG) ||
                       (state_ff == ST_FILL && fifo_valid));

    dft_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_wr_valid (wr_edge && i_reg_sel == `DFT_OFS_DATA && o_transfer_request),
        .o_wr_ready (fifo_ready),
        .i_wr_data  (i_host_data),
        .o_rd_valid (fifo_valid),
        .i_rd_ready (fifo_take || state_ff == ST_FILL),
        .o_rd_data  (fifo_data)
    );

    always @* begin
        case (cnt_ff[2:0])
            3'h1:    id_byte = id_mark;
            3'h2:    id_byte = cyl_lo_ff;
            3'h3:    id_byte = {1'b0, 4'h0, geo_ff[2:0]};
            3'h4:    id_byte = ilv_ff;
            default: id_byte = `DFT_ZERO_BYTE;
        endcase
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            state_ff           <= ST_IDLE;
            cnt_ff             <= 10'h000;
            idx_cnt_ff         <= 8'h00;
            sec_cnt_ff         <= `DFT_RST_BYTE;
            sec_num_ff         <= `DFT_RST_BYTE;
            cyl_lo_ff          <= `DFT_RST_BYTE;
            cyl_hi_ff          <= `DFT_RST_BYTE;
            geo_ff             <= `DFT_RST_BYTE;
            err_ff             <= `DFT_RST_BYTE;
            ilv_ff             <= `DFT_RST_BYTE;
            busy_ff            <= 1'b0;
            error_ff           <= 1'b0;
            corr_ff            <= 1'b0;
            rd_n_d_ff          <= 1'b1;
            wr_n_d_ff          <= 1'b1;
            o_host_data        <= 8'h00;
            o_host_data_oe_n   <= 1'b1;
            o_transfer_request <= 1'b0;
            o_intrq            <= 1'b0;
            o_step             <= 1'b0;
            o_write_gate       <= 1'b0;
            o_write_byte       <= 8'h00;
            o_write_byte_valid <= 1'b0;
            o_drive_sel        <= 4'h1;
            o_head_sel         <= 3'h0;
            o_ecc_mode         <= 1'b0;
            o_precomp_cyl      <= 8'h00;
            o_bad_block        <= 1'b0;
        end else if (i_ce) begin
            rd_n_d_ff          <= i_read_strobe_n;
            wr_n_d_ff          <= i_write_strobe_n;
            o_step             <= 1'b0;
            o_write_byte_valid <= 1'b0;
            o_drive_sel        <= 4'h1 << geo_ff[4:3];               // [R18]
            o_head_sel         <= geo_ff[2:0];                       // [R19]
            o_ecc_mode         <= geo_ff[`DFT_GEO_EXT];              // [R16]
            o_host_data_oe_n   <= !(!i_cs_n && !i_read_strobe_n);
            case (i_reg_sel)                                         // [R15]
                `DFT_OFS_DATA:   o_host_data <= ilv_ff;
                `DFT_OFS_ERRPRE: o_host_data <= err_ff;              // [R21]
                `DFT_OFS_SECCNT: o_host_data <= sec_cnt_ff;
                `DFT_OFS_SECNUM: o_host_data <= sec_num_ff;
                `DFT_OFS_CYLLO:  o_host_data <= cyl_lo_ff;
                `DFT_OFS_CYLHI:  o_host_data <= cyl_hi_ff;
                `DFT_OFS_GEO:    o_host_data <= geo_ff;
                default:         o_host_data <= status;
            endcase
            if (rd_edge && i_reg_sel == `DFT_OFS_STATCMD)
                o_intrq <= 1'b0;
            // Refused while busy
            if (wr_edge && !busy_ff) begin
                case (i_reg_sel)
                    `DFT_OFS_ERRPRE: o_precomp_cyl <= i_host_data;   // [R14]
                    `DFT_OFS_SECCNT: sec_cnt_ff    <= i_host_data;   // [R7]
                    `DFT_OFS_SECNUM: sec_num_ff    <= i_host_data;
                    `DFT_OFS_CYLLO:  cyl_lo_ff     <= i_host_data;
                    `DFT_OFS_CYLHI:  cyl_hi_ff     <= i_host_data;
                    `DFT_OFS_GEO:    geo_ff        <= i_host_data;
                    `DFT_OFS_STATCMD: begin
                        if (state_ff == ST_IDLE && !o_transfer_request &&
                            (i_host_data[7:4] == `DFT_CMD_FORMAT ||
                             i_host_data[7:4] == `DFT_CMD_WRITE)) begin
                            err_ff             <= 8'h00;
                            error_ff           <= 1'b0;
                            corr_ff            <= 1'b0;
                            o_intrq            <= 1'b0;
                            o_transfer_request <= 1'b1;              // [R2]
                            cnt_ff <= (i_host_data[7:4] == `DFT_CMD_WRITE &&
                                       i_host_data[`DFT_WRLONG_BIT]) ?
                                      sec_bytes + `DFT_LONG_EXTRA : sec_bytes;  // [R1]
                            state_ff <= (i_host_data[7:4] == `DFT_CMD_FORMAT) ?
                                        ST_FILL : ST_WLONG;
                        end
                    end
                    default: ;
                endcase
            end
            case (state_ff)
                ST_IDLE: ;
                ST_FILL, ST_WLONG: begin
                    // Byte per data write; last byte ends the request
                    if (wr_edge && i_reg_sel == `DFT_OFS_DATA && o_transfer_request) begin
                        ilv_ff <= i_host_data;
                        if (cnt_ff == 10'h001) begin
                            o_transfer_request <= 1'b0;              // [R2] [R1]
                            busy_ff            <= 1'b1;              // [R3]
                            state_ff           <= ST_CHECK;
                        end
                        cnt_ff <= cnt_ff - 10'h001;
                    end
                end
                ST_CHECK: begin
                    if (!sk_sync_ff[2] || !rdy_sync_ff[2] || wf_sync_ff[2]) begin
                        err_ff[`DFT_ER_ABORT] <= 1'b1;               // [R3] [R22]
                        error_ff <= 1'b1;
                        o_intrq  <= 1'b1;
                        busy_ff  <= 1'b0;
                        state_ff <= ST_IDLE;
                    end else begin
                        o_step     <= 1'b1;                          // [R4]
                        idx_cnt_ff <= 8'h00;
                        state_ff   <= ST_SEEK;
                    end
                end
                ST_SEEK: begin
                    if (!cnt_ff[3])
                        cnt_ff <= cnt_ff + 10'h001;
                    if (sk_sync_ff[2] && cnt_ff[3]) begin
                        state_ff <= ST_PRE;
                    end else if (idx_rise) begin
                        if (idx_cnt_ff == SEEK_INDEX_LIMIT - 8'h01) begin
                            err_ff[`DFT_ER_ABORT] <= 1'b1;           // [R4]
                            error_ff <= 1'b1;                        // [R22]
                            o_intrq  <= 1'b1;
                            busy_ff  <= 1'b0;
                            state_ff <= ST_IDLE;
                        end
                        idx_cnt_ff <= idx_cnt_ff + 8'h01;
                    end
                end
                ST_PRE, ST_BACK: begin
                    o_write_gate <= 1'b1;
                    if (bs_rise) begin
                        o_write_byte       <= `DFT_FILL_BYTE;        // [R5] [R8]
                        o_write_byte_valid <= 1'b1;
                    end
                    if (idx_rise) begin
                        if (state_ff == ST_BACK) begin
                            o_write_gate <= 1'b0;
                            o_intrq      <= 1'b1;                    // [R8]
                            busy_ff      <= 1'b0;
                            state_ff     <= ST_IDLE;
                        end else if (sec_cnt_ff == 8'h00) begin
                            state_ff <= ST_BACK;
                        end else begin
                            cnt_ff   <= 10'h000;
                            state_ff <= ST_ID;                       // [R6]
                        end
                    end
                end
                ST_ID: begin
                    if (bs_rise) begin
                        o_write_byte       <= id_byte;
                        o_write_byte_valid <= 1'b1;
                        o_bad_block <= (cnt_ff[2:0] == 3'h3) && id_byte[7];  // [R9]
                        if (cnt_ff[3:0] == `DFT_ID_BYTES - 4'h1) begin
                            o_write_gate <= 1'b0;
                            cnt_ff       <= 10'h000;
                            state_ff     <= ST_GAPON;
                        end else begin
                            cnt_ff <= cnt_ff + 10'h001;
                        end
                    end
                end
                ST_GAPON: begin
                    if (bs_rise) begin
                        if (cnt_ff[3:0] == `DFT_GATE_DELAY - 4'h1) begin
                            o_write_gate <= 1'b1;                    // [R10]
                            cnt_ff       <= 10'h000;
                            state_ff     <= ST_ZERO;
                        end else begin
                            cnt_ff <= cnt_ff + 10'h001;
                        end
                    end
                end
                ST_ZERO: begin
                    if (bs_rise) begin
                        o_write_byte       <= `DFT_ZERO_BYTE;        // [R11]
                        o_write_byte_valid <= 1'b1;
                        if (cnt_ff[4:0] == `DFT_PREAMBLE - 5'h01) begin
                            cnt_ff   <= 10'h000;
                            state_ff <= ST_DATA;
                        end else begin
                            cnt_ff <= cnt_ff + 10'h001;
                        end
                    end
                end
                ST_DATA, ST_CHK: begin
                    // Nulled data field, then its check bytes
                    if (bs_rise) begin
                        o_write_byte       <= `DFT_ZERO_BYTE;
                        o_write_byte_valid <= 1'b1;
                        if (state_ff == ST_DATA && cnt_ff == sec_bytes - 10'h001) begin
                            cnt_ff   <= 10'h000;
                            state_ff <= ST_CHK;
                        end else if (state_ff == ST_CHK &&
                                     cnt_ff[2:0] == chk_len - 3'h1) begin
                            cnt_ff   <= 10'h000;
                            state_ff <= ST_GAPOF;
                        end else begin
                            cnt_ff <= cnt_ff + 10'h001;
                        end
                    end
                end
                ST_GAPOF: begin
                    if (bs_rise) begin
                        if (cnt_ff[3:0] == `DFT_GATE_DELAY - 4'h1) begin
                            cnt_ff   <= 10'h000;
                            state_ff <= ST_GAP3;
                        end else begin
                            cnt_ff <= cnt_ff + 10'h001;
                        end
                    end
                end
                ST_GAP3: begin
                    if (bs_rise) begin
                        o_write_byte       <= `DFT_FILL_BYTE;        // [R13]
                        o_write_byte_valid <= 1'b1;
                        if (cnt_ff[4:0] == gap_len - 5'h01) begin
                            sec_cnt_ff <= sec_cnt_ff - 8'h01;        // [R6]
                            cnt_ff     <= 10'h000;
                            state_ff   <= (sec_cnt_ff == 8'h01) ? ST_BACK : ST_ID;
                        end else begin
                            cnt_ff <= cnt_ff + 10'h001;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // dft_task_file

// ---- bench/dft_task_file_monitor.sv ----
// Port assertions for the task file block
`timescale 1ns/100ps
module dft_task_file_monitor (
    input wire       i_core_clk,
    input wire       i_rst,
    input wire       i_cs_n,
    input wire [2:0] i_reg_sel,
    input wire       i_read_strobe_n,
    input wire       i_write_strobe_n,
    input wire [7:0] i_host_data,
    input wire       o_host_data_oe_n,
    input wire       o_intrq,
    input wire       o_step,
    input wire [7:0] o_write_byte,
    input wire       o_write_byte_valid,
    input wire [3:0] o_drive_sel,
    input wire [2:0] o_head_sel,
    input wire       o_ecc_mode,
    input wire [7:0] o_precomp_cyl
);
    reg  [7:0] geo_ff;
    reg  [7:0] pre_ff;
    reg  [7:0] cyl_ff;
    wire       wr_lo = !i_cs_n && !i_write_strobe_n;
    // Data under a low strobe is what the trailing edge takes
    always @(posedge i_core_clk) begin
        if (wr_lo && i_reg_sel == 3'h6) geo_ff <= i_host_data;
        if (wr_lo && i_reg_sel == 3'h1) pre_ff <= i_host_data;
        if (wr_lo && i_reg_sel == 3'h5) cyl_ff <= i_host_data;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_wr(a);
        !i_cs_n && i_reg_sel == a && $rose(i_write_strobe_n);
    endsequence
    sequence s_rd(a);
        !i_cs_n && i_reg_sel == a && $rose(i_read_strobe_n);
    endsequence
    property p_geo;
        s_wr(3'h6) |-> ##[1:3] (o_ecc_mode == geo_ff[7] && o_head_sel == geo_ff[2:0]
            && o_drive_sel == (4'h1 << geo_ff[4:3]));
    endproperty
    property p_drv;
        $onehot(o_drive_sel);
    endproperty
    property p_pre;
        s_wr(3'h1) |-> ##[1:3] o_precomp_cyl == pre_ff;
    endproperty
    property p_oe;
        o_host_data_oe_n == !$past(!i_cs_n && !i_read_strobe_n);
    endproperty
    property p_step;
        o_step |=> !o_step;
    endproperty
    property p_wbv;
        o_write_byte_valid |=> !o_write_byte_valid [*2];
    endproperty
    property p_mark;
        o_write_byte_valid && o_write_byte[7:2] == 6'h3F
            |-> o_write_byte[1:0] == (cyl_ff[1:0] ^ 2'h2);
    endproperty
    property p_irq;
        o_intrq and s_rd(3'h7) |-> ##[1:3] !o_intrq;
    endproperty
    a_geo: assert property (p_geo) else $error("geometry outputs wrong");
    a_drv: assert property (p_drv) else $error("drive select not one-hot");
    a_pre: assert property (p_pre) else $error("precomp not written");
    a_oe: assert property (p_oe) else $error("data enable wrong");
    a_step: assert property (p_step) else $error("step too long");
    a_wbv: assert property (p_wbv) else $error("byte valid too long");
    a_mark: assert property (p_mark) else $error("id mark wrong");
    a_irq: assert property (p_irq) else $error("irq not cleared");
endmodule // dft_task_file_monitor
bind dft_task_file dft_task_file_monitor u_dft_task_file_monitor (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_reg_sel(i_reg_sel),
    .i_read_strobe_n(i_read_strobe_n), .i_write_strobe_n(i_write_strobe_n),
    .i_host_data(i_host_data), .o_host_data_oe_n(o_host_data_oe_n), .o_intrq(o_intrq),
    .o_step(o_step), .o_write_byte(o_write_byte), .o_write_byte_valid(o_write_byte_valid),
    .o_drive_sel(o_drive_sel), .o_head_sel(o_head_sel), .o_ecc_mode(o_ecc_mode),
    .o_precomp_cyl(o_precomp_cyl));

// ---- bench/dft_drive_model.sv ----
// Drive-side model: index, byte timing, seek settling
`timescale 1ns/100ps
module dft_drive_model (
    input  wire       i_core_clk,
    input  wire       i_slow,
    input  wire       i_step,
    input  wire       i_wbv,
    input  wire [7:0] i_wbyte,
    output reg        o_index = 1'b0,
    output reg        o_seek_done = 1'b1,
    output reg        o_byte_strobe = 1'b0,
    output reg  [7:0] o_marks = 8'h00
);
    integer cyc_ff = 0;
    integer settle_ff = 0;
    // 500 byte times per turn
    always @(posedge i_core_clk) begin
        cyc_ff <= cyc_ff + 1;
        o_byte_strobe <= (cyc_ff % 8) < 4;
        o_index <= (cyc_ff % 4000) < 16;
        // Slow mode never settles
        if (i_step) settle_ff <= i_slow ? -1 : 128;
        else if (settle_ff > 0) settle_ff <= settle_ff - 1;
        o_seek_done <= settle_ff == 0;
        if (i_wbv && i_wbyte[7:2] == 6'h3F) o_marks <= o_marks + 8'h01;
    end
endmodule // dft_drive_model

// ---- bench/dft_task_file_test.sv ----
// Self-checking bench for the task file block
`timescale 1ns/100ps
module dft_task_file_test;
    reg         clk = 1'b0, rst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    reg         fault = 1'b0, slow = 1'b0;
    reg  [2:0]  sel = 3'h0;
    reg  [7:0]  wdat = 8'h00, rdat, m0;
    reg  [18:0] rows [0:5];
    wire [7:0]  hdo, wb, pre, marks;
    wire [3:0]  dsel;
    wire [2:0]  hsel;
    wire        oe_n, req, irq, idx, sk, bs, stp, wg, wbv, ecc, bad;
    integer     mismatches = 0, comparisons = 0, i;
    always #5 clk = ~clk;
    dft_task_file #(.SEEK_INDEX_LIMIT(8'h04)) u_dft_task_file (
        .i_core_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_cs_n(cs_n), .i_reg_sel(sel),
        .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_host_data(wdat),
        .o_host_data(hdo), .o_host_data_oe_n(oe_n), .o_transfer_request(req),
        .o_intrq(irq), .i_index(idx), .i_seek_complete(sk), .i_drive_ready(1'b1),
        .i_write_fault(fault), .i_byte_strobe(bs), .o_step(stp), .o_write_gate(wg),
        .o_write_byte(wb), .o_write_byte_valid(wbv), .o_drive_sel(dsel),
        .o_head_sel(hsel), .o_ecc_mode(ecc), .o_precomp_cyl(pre), .o_bad_block(bad));
    dft_drive_model u_dft_drive_model (.i_core_clk(clk), .i_slow(slow), .i_step(stp),
        .i_wbv(wbv), .i_wbyte(wb), .o_index(idx), .o_seek_done(sk),
        .o_byte_strobe(bs), .o_marks(marks));
    task check(input string nm, input [7:0] exp, input [7:0] got);
        begin
            comparisons++;
            if (got !== exp) begin
                mismatches++;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(negedge clk);
            {cs_n, wr_n, sel, wdat} = {2'b00, a, d};
            @(negedge clk);
            wr_n = 1'b1;
            @(negedge clk);
            cs_n = 1'b1;
        end
    endtask
    task rd(input [2:0] a);
        begin
            @(negedge clk);
            {cs_n, rd_n, sel} = {2'b00, a};
            repeat (3) @(negedge clk);
            rdat = hdo;
            rd_n = 1'b1;
            @(negedge clk);
            cs_n = 1'b1;
        end
    endtask
    task fmt;
        begin
            wr(3'h2, 8'h02);
            wr(3'h7, 8'h50);
            for (i = 0; i < 128; i++) begin
                wait (req === 1'b1);
                wr(3'h0, i[7:0]);
            end
            wait (irq === 1'b1);
            rd(3'h7);
        end
    endtask
    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        #800000;
        mismatches++;
        complete_run;
    end
    initial begin
        rows[0] = {3'h2, 8'hA5, 8'hA5}; rows[1] = {3'h3, 8'h3C, 8'h3C};
        rows[2] = {3'h4, 8'h12, 8'h12}; rows[3] = {3'h5, 8'h02, 8'h02};
        rows[4] = {3'h6, 8'hF5, 8'hF5}; rows[5] = {3'h1, 8'h7E, 8'h00};
        repeat (6) @(negedge clk);
        rst = 1'b0;
        check("oe_idle", 8'h01, {7'h00, oe_n});
        rd(3'h7);
        check("status", 8'h00, rdat & 8'h81);
        for (i = 0; i < 6; i++) wr(rows[i][18:16], rows[i][15:8]);
        for (i = 0; i < 6; i++) begin
            rd(rows[i][18:16]);
            check("readback", rows[i][7:0], rdat);
        end
        check("precomp", 8'h7E, pre);
        check("drive", 8'h04, {4'h0, dsel});
        check("head", 8'h05, {5'h00, hsel});
        check("ecc", 8'h01, {7'h00, ecc});
        m0 = marks;
        fmt;
        check("done", 8'h00, rdat & 8'h81);
        check("ids", 8'h02, marks - m0);
        rd(3'h2);
        check("count", 8'h00, rdat);
        check("irq_clr", 8'h00, {7'h00, irq});
        fault = 1'b1;
        fmt;
        check("fault", 8'h01, rdat & 8'h81);
        rd(3'h1);
        check("abort", 8'h04, rdat & 8'h04);
        fault = 1'b0;
        slow = 1'b1;
        fmt;
        check("seek", 8'h01, rdat & 8'h81);
        rd(3'h1);
        check("seek_abort", 8'h04, rdat & 8'h04);
        complete_run;
    end
endmodule // dft_task_file_test
